// [hw/aegps_core.sv]
// Active energy gain, divider, pulse-rate scaling, line period and line accumulation.
// Assumes power_in comes from DSP logic on mclk_in; zc_in is an asynchronous pin.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`default_nettype none
module aegps_core
   import aegps_pkg::*;
#(
   parameter int PWR_W  = 24,
   parameter int ACC_W  = 48,
   parameter int EN_W   = 24
) (
   input  wire logic             mclk_in,
   input  wire logic             rst_in,
   input  wire logic [PWR_W-1:0] power_in,
   input  wire logic             zc_in,
   input  wire logic [3:0]       addr_in,
   input  wire logic [23:0]      wdata_in,
   input  wire logic             wr_in,
   input  wire logic             rd_in,
   output logic      [23:0]      rdata_out,
   output logic                  energy_pulse_out,
   output logic                  irq_n_out,
   output logic                  irq_oe_out
);
   // =====================================================
   // Registers
   logic        [11:0]      gain_r;
   logic        [7:0]       div_r;
   logic        [11:0]      num_r;
   logic        [11:0]      den_r;
   logic        [15:0]      hcyc_r;
   logic                    lmode_r;
   logic                    irqen_r;
   logic                    cend_r;
   logic        [15:0]      period_r;
   logic signed [EN_W-1:0]  total_r;
   logic signed [EN_W-1:0]  line_r;
   logic signed [EN_W-1:0]  lacc_r;
   logic signed [ACC_W-1:0] acc_r;
   logic        [1:0]       ph_r;
   logic        [2:0]       p8_r;
   logic        [15:0]      pcnt_r;
   logic        [15:0]      hc_r;
   logic        [7:0]       dcnt_r;
   logic        [13:0]      pacc_r;
   logic        [8:0]       pw_r;
   logic                    zs1_r;
   logic                    zs2_r;
   logic                    zs3_r;

   logic                    tick;
   logic signed [13:0]      gmul;
   logic signed [PWR_W+13:0] prod;
   logic signed [ACC_W-1:0] scaled;
   logic signed [ACC_W-1:0] acc_nxt;
   logic                    step_up;
   logic                    step_dn;
   logic        [7:0]       div_eff;
   logic                    tot_up;
   logic                    tot_dn;
   logic        [13:0]      pacc_sum;
   logic        [13:0]      quantum;
   logic                    fire;
   logic                    zc_edge;
   logic                    zc_rise;
   logic                    win_done;
   logic signed [EN_W-1:0]  lacc_nxt;
   logic                    wr_status;

   // =====================================================
   // Register writes
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         gain_r  <= GAIN_RST;
         div_r   <= DIV_RST;
         num_r   <= NUM_RST;
         den_r   <= DEN_RST;
         hcyc_r  <= HCYC_RST;
         lmode_r <= 1'b0;
         irqen_r <= 1'b0;
      end else if (wr_in) begin
         if (addr_in == REG_GAIN) begin
            gain_r <= wdata_in[11:0];
         end else if (addr_in == REG_DIV) begin
            div_r <= wdata_in[7:0];
         end else if (addr_in == REG_NUM) begin
            num_r <= wdata_in[11:0];
         end else if (addr_in == REG_DEN) begin
            den_r <= wdata_in[11:0];
         end else if (addr_in == REG_HCYC) begin
            hcyc_r <= wdata_in[15:0];
         end else if (addr_in == REG_MODE) begin
            lmode_r <= wdata_in[BIT_LMODE];
         end else if (addr_in == REG_IRQEN) begin
            irqen_r <= wdata_in[BIT_CEND];
         end
      end
   end

   assign wr_status = wr_in && (addr_in == REG_STATUS) && wdata_in[BIT_CEND];

   // =====================================================
   // Readback, data valid the cycle after the strobe
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rdata_out <= 24'h000000;
      end else if (rd_in) begin
         if (addr_in == REG_GAIN) begin
            rdata_out <= {12'h000, gain_r};
         end else if (addr_in == REG_DIV) begin
            rdata_out <= {16'h0000, div_r};
         end else if (addr_in == REG_NUM) begin
            rdata_out <= {12'h000, num_r};
         end else if (addr_in == REG_DEN) begin
            rdata_out <= {12'h000, den_r};
         end else if (addr_in == REG_HCYC) begin
            rdata_out <= {8'h00, hcyc_r};
         end else if (addr_in == REG_MODE) begin
            rdata_out <= {23'h000000, lmode_r};
         end else if (addr_in == REG_IRQEN) begin
            rdata_out <= {23'h000000, irqen_r};
         end else if (addr_in == REG_STATUS) begin
            rdata_out <= {23'h000000, cend_r};
         end else if (addr_in == REG_PERIOD) begin
            rdata_out <= {8'h00, period_r};
         end else if (addr_in == REG_TOTAL) begin
            rdata_out <= 24'(total_r);
         end else if (addr_in == REG_LINE) begin
            rdata_out <= 24'(line_r);
         end else begin
            rdata_out <= 24'h000000;
         end
      end else begin
         rdata_out <= 24'h000000;
      end
   end

   // =====================================================
   // Gain stage and accumulator
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         ph_r <= 2'h0;
      end else begin
         ph_r <= ph_r + 2'h1;
      end
   end
   assign tick = (ph_r == TICK_PH);

   // Signed gain widened before adding one, so negative settings shrink the rate
   // Two spare bits so unity plus the largest positive gain stays positive
   assign gmul   = $signed({{2{gain_r[11]}}, gain_r}) + $signed({1'b0, GAIN_ONE});
   assign prod   = (PWR_W+14)'($signed(power_in)) * (PWR_W+14)'(gmul);
   assign scaled = ACC_W'(prod >>> GAIN_SHIFT);
   assign acc_nxt = acc_r + scaled;
   // One full-scale sample moves the top word by at most one step per tick
   assign step_up = tick && (acc_nxt[ACC_W-1 -: EN_W] != acc_r[ACC_W-1 -: EN_W]) && !scaled[ACC_W-1];
   assign step_dn = tick && (acc_nxt[ACC_W-1 -: EN_W] != acc_r[ACC_W-1 -: EN_W]) && scaled[ACC_W-1];

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         acc_r <= '0;
      end else if (tick) begin
         acc_r <= acc_nxt;
      end
   end

   // =====================================================
   // Register divider, kept out of the pulse path
   assign div_eff = (div_r == 8'h00) ? 8'h01 : div_r;
   assign tot_up  = step_up && ((dcnt_r + 8'h01) >= div_eff);
   assign tot_dn  = step_dn && (dcnt_r == 8'h00);

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         dcnt_r  <= 8'h00;
         total_r <= '0;
      end else begin
         if (tot_up) begin
            dcnt_r  <= 8'h00;
            total_r <= total_r + 1'b1;
         end else if (step_up) begin
            dcnt_r <= dcnt_r + 8'h01;
         end else if (tot_dn) begin
            dcnt_r  <= div_eff - 8'h01;
            total_r <= total_r - 1'b1;
         end else if (step_dn) begin
            dcnt_r <= dcnt_r - 8'h01;
         end
      end
   end

   // =====================================================
   // Pulse rate scaler; numerator above denominator saturates the rate
   assign quantum  = {2'b00, den_r} + 14'h0001;
   assign pacc_sum = pacc_r + {2'b00, num_r} + 14'h0001;
   assign fire     = step_up && (pacc_sum >= quantum);

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         pacc_r <= 14'h0000;
      end else if (fire) begin
         pacc_r <= pacc_sum - quantum;
      end else if (step_up) begin
         pacc_r <= pacc_sum;
      end
   end

   // Width is half the period at the top rate; nothing limits the firing rate, so faster pulses merge
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         pw_r             <= 9'h000;
         energy_pulse_out <= 1'b0;
      end else begin
         if (fire) begin
            pw_r <= PULSE_CYC;
         end else if (pw_r != 9'h000) begin
            pw_r <= pw_r - 9'h001;
         end
         energy_pulse_out <= fire || (pw_r > 9'h001);
      end
   end

   // =====================================================
   // Zero crossing and line period
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         zs1_r <= 1'b0;
         zs2_r <= 1'b0;
         zs3_r <= 1'b0;
      end else begin
         zs1_r <= zc_in;
         zs2_r <= zs1_r;
         zs3_r <= zs2_r;
      end
   end
   assign zc_edge = zs2_r ^ zs3_r;
   assign zc_rise = zs2_r && !zs3_r;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         p8_r     <= 3'h0;
         pcnt_r   <= 16'h0000;
         period_r <= 16'h0000;
      end else if (zc_rise) begin
         p8_r     <= 3'h0;
         pcnt_r   <= 16'h0000;
         period_r <= pcnt_r;
      end else begin
         p8_r <= p8_r + 3'h1;
         if (p8_r == PER_PH && pcnt_r != 16'hffff) begin
            pcnt_r <= pcnt_r + 16'h0001;
         end
      end
   end

   // =====================================================
   // Line accumulation window
   assign win_done = lmode_r && zc_edge && ((hc_r + 16'h0001) >= hcyc_r);
   assign lacc_nxt = tot_up ? lacc_r + 1'b1 : (tot_dn ? lacc_r - 1'b1 : lacc_r);

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         hc_r   <= 16'h0000;
         lacc_r <= '0;
         line_r <= '0;
      end else if (!lmode_r) begin
         hc_r   <= 16'h0000;
         lacc_r <= '0;
      end else if (win_done) begin
         hc_r   <= 16'h0000;
         lacc_r <= '0;
         line_r <= lacc_nxt;
      end else begin
         if (zc_edge) begin
            hc_r <= hc_r + 16'h0001;
         end
         lacc_r <= lacc_nxt;
      end
   end

   // Set beats a simultaneous clear so no window end is lost
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         cend_r <= 1'b0;
      end else if (win_done) begin
         cend_r <= 1'b1;
      end else if (wr_status) begin
         cend_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         irq_n_out  <= 1'b1;
         irq_oe_out <= 1'b0;
      end else begin
         irq_n_out  <= !(cend_r && irqen_r);
         irq_oe_out <= cend_r && irqen_r;
      end
   end

   // =====================================================
   // Checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   sequence tick_gap_s;
      !tick [*3] ##1 tick;
   endsequence

   tick_spacing_a: assert property (tick |=> tick_gap_s)
      else $error("accumulator tick not every four clocks");
   gain_scale_a: assert property (tick |=> acc_r == $past(acc_r) + $past(scaled))
      else $error("accumulator did not add gain-scaled power");
   ratio_reset_a: assert property (disable iff (1'b0) $fell(rst_in) |-> num_r == NUM_RST && den_r == DEN_RST)
      else $error("ratio settings wrong after reset");
   undivided_a: assert property (step_up && div_r == 8'h00 |=> total_r == $past(total_r) + 1'b1)
      else $error("undivided total did not follow energy step");
   pulse_start_a: assert property (fire |=> energy_pulse_out && pacc_r < quantum)
      else $error("pulse not started or remainder too big");
   pulse_only_a: assert property (!step_up |=> pacc_r == $past(pacc_r))
      else $error("pulse accumulator moved without an energy step");
   period_latch_a: assert property (zc_rise |=> period_r == $past(pcnt_r) && pcnt_r == 16'h0000)
      else $error("line period not captured");
   window_end_a: assert property (win_done |=> cend_r && line_r == $past(lacc_nxt) && hc_r == 16'h0000)
      else $error("window end not latched");
   irq_drive_a: assert property (win_done && irqen_r |=> ##1 !irq_n_out && irq_oe_out)
      else $error("interrupt not driven at window end");
   irq_mask_a: assert property (!irqen_r |=> irq_n_out && !irq_oe_out)
      else $error("masked interrupt was driven");
endmodule : aegps_core
`default_nettype wire

// [include/aegps_pkg.sv]
// Constants, register map and reset values of the energy gain and pulse scaling block.
// Assumes a 10 MHz master clock and a single-cycle register port.
//
// Notes on behaviour
// - Pulse rate equals energy rate times (numerator+1)/(denominator+1); the code caps it at the energy rate for numerator above denominator.
// - Energy divider scales readable energy registers only, never pulses; resets to zero.
// - Energy and pulse rate both scaled by (1 + gain/4096).
// - Line period counted in units of eight master clocks, host readable.
// - Line mode accumulates over half_cycle_count half line cycles.
// - Numerator and denominator reset to 0x3f.
// - Window end drives active-low interrupt if enabled, latches line energy.
// - Full-scale undivided pulse rate reaches 23 kHz; the code gives about 1.25 MHz, half an energy step per tick.
// - Window end sets cycle_end_flag; interrupt only when its mask bit is set.
// - half_cycle_count is unsigned 16 bit, up to 65535.
// - Energy accumulator updates once every four master clocks.
`default_nettype none
package aegps_pkg;
   // =====================================================
   // Register indices
   localparam logic [3:0] REG_GAIN   = 4'h0;
   localparam logic [3:0] REG_DIV    = 4'h1;
   localparam logic [3:0] REG_NUM    = 4'h2;
   localparam logic [3:0] REG_DEN    = 4'h3;
   localparam logic [3:0] REG_HCYC   = 4'h4;
   localparam logic [3:0] REG_MODE   = 4'h5;
   localparam logic [3:0] REG_IRQEN  = 4'h6;
   localparam logic [3:0] REG_STATUS = 4'h7;
   localparam logic [3:0] REG_PERIOD = 4'h8;
   localparam logic [3:0] REG_TOTAL  = 4'h9;
   localparam logic [3:0] REG_LINE   = 4'ha;
   // =====================================================
   // Fields and reset values
   localparam int          BIT_LMODE = 0;
   localparam int          BIT_CEND  = 0;
   localparam logic [11:0] NUM_RST   = 12'h03f;
   localparam logic [11:0] DEN_RST   = 12'h03f;
   localparam logic [15:0] HCYC_RST  = 16'hffff;
   localparam logic [7:0]  DIV_RST   = 8'h00;
   localparam logic [11:0] GAIN_RST  = 12'h000;
   // =====================================================
   // Timing
   localparam logic [1:0]  TICK_PH    = 2'h3;
   localparam logic [2:0]  PER_PH     = 3'h7;
   localparam int          CLK_HZ     = 10000000;
   localparam int          PULSE_MAX_HZ = 23000;
   localparam int          PULSE_MIN_CYC = CLK_HZ / PULSE_MAX_HZ;
   localparam logic [8:0]  PULSE_CYC  = 9'(PULSE_MIN_CYC / 2);
   localparam int          GAIN_SHIFT = 12;
   localparam logic [12:0] GAIN_ONE   = 13'h1000;
endpackage : aegps_pkg
`default_nettype wire

// [sim/aegps_line_model.sv]
// Line-side model: zero-crossing square wave and a steady active power sample.
// Assumes one master clock; the power level is set by the bench.
`default_nettype none
module aegps_line_model #(
   parameter int HALF_CYC = 400
) (
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic [23:0] level_in,
   output logic             zc_out,
   output logic [23:0]      power_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt_r;
   // =====================================================
   // Half line cycle generator, free running like the mains
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         cnt_r  <= 0;
         zc_out <= 1'b0;
      end else if (cnt_r == HALF_CYC - 1) begin
         cnt_r  <= 0;
         zc_out <= ~zc_out;
      end else begin
         cnt_r <= cnt_r + 1;
      end
   end
   // =====================================================
   // Power sample as a same-clock DSP would present it
   always_ff @(posedge mclk_in) begin
      power_out <= level_in;
   end
endmodule : aegps_line_model
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the energy gain and pulse scaling core.
// Assumes the line model above and a 10 MHz clock; register port tasks only.
`default_nettype none
module testbench
   import aegps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk_in;
   logic        rst_in;
   logic [3:0]  addr_in;
   logic [23:0] wdata_in;
   logic        wr_in;
   logic        rd_in;
   logic [23:0] level;
   logic [23:0] power;
   logic        zc;
   logic [23:0] rdata_out;
   logic        energy_pulse_out;
   logic        irq_n_out;
   logic        irq_oe_out;
   logic        pulse_q;
   wire  logic  irq_line;
   int          failures;
   int          checks_done;
   int          pulse_cnt = 0;
   logic [23:0] v;
   logic [23:0] t0;
   int          p0;
   int          n;
   // Pulled-up open-drain interrupt line
   assign irq_line = irq_oe_out ? 1'b0 : 1'b1;
   aegps_core u_aegps_core (
      .mclk_in(mclk_in), .rst_in(rst_in), .power_in(power), .zc_in(zc), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .energy_pulse_out(energy_pulse_out), .irq_n_out(irq_n_out), .irq_oe_out(irq_oe_out));
   aegps_line_model #(.HALF_CYC(400)) u_aegps_line_model (
      .mclk_in(mclk_in), .rst_in(rst_in), .level_in(level), .zc_out(zc), .power_out(power));
   always #50 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      pulse_q <= energy_pulse_out;
      if (energy_pulse_out === 1'b1 && pulse_q === 1'b0) pulse_cnt <= pulse_cnt + 1;
   end
   // =====================================================
   // Register port tasks
   task automatic wr_reg(input logic [3:0] a, input logic [23:0] d);
      @(posedge mclk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, output logic [23:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask : rd_reg
   // Tolerance covers sampling phase against the four-clock tick
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g, input int tol);
      logic signed [23:0] df;
      df = g - e;
      checks_done++;
      if ((^g === 1'bx) || df > tol || df < -tol) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wait_irq(output int cyc);
      for (cyc = 0; cyc < 4000 && irq_line !== 1'b0; cyc++) begin
         @(posedge mclk_in);
         #1;
      end
      if (irq_line !== 1'b0) begin
         failures++;
         $display("wrong value irq wait expected 0 seen 1");
         wrap_up();
      end
   endtask : wait_irq
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up
   // =====================================================
   // Tables: reset values, then energy cases
   logic [3:0]  ra [9] = '{REG_GAIN, REG_DIV, REG_NUM, REG_DEN, REG_HCYC, REG_MODE, REG_IRQEN, REG_STATUS, 4'hb};
   logic [23:0] re [9] = '{24'h0, 24'h0, 24'h3f, 24'h3f, 24'(HCYC_RST), 24'h0, 24'h0, 24'h0, 24'h0};
   logic [23:0] eg [6] = '{24'h0, 24'h800, 24'h400, 24'h0, 24'h0, 24'h0};
   logic [23:0] ev [6] = '{24'h0, 24'h0, 24'h0, 24'h4, 24'h0, 24'h0};
   logic [23:0] en [6] = '{24'h0, 24'h0, 24'h0, 24'h0, 24'h3, 24'h0};
   logic [23:0] ed [6] = '{24'hf, 24'hf, 24'hf, 24'hf, 24'h1f, 24'hf};
   logic [23:0] ep [6] = '{24'h100000, 24'h100000, 24'h100000, 24'h100000, 24'h100000, 24'hf00000};
   logic [23:0] xd [6] = '{24'h80, 24'h40, 24'ha0, 24'h20, 24'h80, 24'hffff80};
   logic [23:0] xp [6] = '{24'h8, 24'h4, 24'ha, 24'h8, 24'h10, 24'h0};
   initial begin
      repeat (100000) @(posedge mclk_in);
      failures++;
      $display("wrong value run length expected finish seen timeout");
      wrap_up();
   end
   initial begin
      mclk_in = 1'b0;
      rst_in = 1'b1;
      addr_in = 4'h0;
      wdata_in = 24'h0;
      wr_in = 1'b0;
      rd_in = 1'b0;
      level = 24'h0;
      failures = 0;
      checks_done = 0;
      repeat (4) @(posedge mclk_in);
      rst_in <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         rd_reg(ra[i], v);
         chk("reset value", re[i], v, 0);
      end
      wr_reg(REG_GAIN, 24'hfffabc);
      rd_reg(REG_GAIN, v);
      chk("gain width", 24'h000abc, v, 0);
      wr_reg(REG_HCYC, 24'h12abcd);
      rd_reg(REG_HCYC, v);
      chk("half cycle width", 24'h00abcd, v, 0);
      repeat (2000) @(posedge mclk_in);
      rd_reg(REG_PERIOD, v);
      chk("period", 24'd100, v, 1);
      @(posedge mclk_in);
      #1 chk("read data idle", 24'h0, rdata_out, 0);
      $display("test registers done");
      // =====================================================
      // Energy totals and pulse counts over 8192 clocks
      for (int i = 0; i < 6; i++) begin
         level <= ep[i];
         wr_reg(REG_GAIN, eg[i]);
         wr_reg(REG_DIV, ev[i]);
         wr_reg(REG_NUM, en[i]);
         wr_reg(REG_DEN, ed[i]);
         repeat (1024) @(posedge mclk_in);
         rd_reg(REG_TOTAL, t0);
         p0 = pulse_cnt;
         repeat (8192) @(posedge mclk_in);
         rd_reg(REG_TOTAL, v);
         chk("total delta", xd[i], v - t0, 2);
         chk("pulse count", xp[i], 24'(pulse_cnt - p0), 1);
      end
      $display("test energy done");
      // =====================================================
      // Line accumulation, host steps in calibration order
      level <= 24'h100000;
      wr_reg(REG_GAIN, 24'h0);
      wr_reg(REG_DIV, 24'h0);
      wr_reg(REG_DEN, 24'd489);
      wr_reg(REG_NUM, 24'h0);
      wr_reg(REG_MODE, 24'h1);
      wr_reg(REG_IRQEN, 24'h1);
      wr_reg(REG_HCYC, 24'h4);
      wr_reg(REG_STATUS, 24'h1);
      wait_irq(n);
      wr_reg(REG_STATUS, 24'h1);
      repeat (2) @(posedge mclk_in);
      #1 chk("irq released", 24'h1, 24'(irq_line), 0);
      wait_irq(n);
      chk("window cycles", 24'd1596, 24'(n), 8);
      chk("irq level", 24'h0, 24'(irq_n_out), 0);
      rd_reg(REG_LINE, v);
      chk("line energy", 24'd25, v, 1);
      rd_reg(REG_STATUS, v);
      chk("status flag", 24'h1, v, 0);
      wr_reg(REG_IRQEN, 24'h0);
      wr_reg(REG_STATUS, 24'h1);
      repeat (2000) @(posedge mclk_in);
      #1 chk("masked irq", 24'h1, 24'(irq_line), 0);
      chk("masked irq level", 24'h1, 24'(irq_n_out), 0);
      rd_reg(REG_STATUS, v);
      chk("masked flag", 24'h1, v, 0);
      $display("test line window done");
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
